//--- monitor_pin_consts.vh
`ifndef MONITOR_PIN_CONSTS_VH
`define MONITOR_PIN_CONSTS_VH

// Register offsets
`define REG_CONFIG 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_TACH_MODE 4'h3
`define REG_PIN_DIR 4'h4
`define REG_PIN_OUT 4'h5
`define REG_PIN_IN 4'h6
`define REG_FAN_EN 4'h7
`define REG_ADDR_LSB 4'h8
`define REG_ROUND 4'h9
`define REG_FAN_SEL 4'ha
`define REG_FAN_COUNT 4'hb
`define REG_INTRUSION 4'hc

// Field positions
`define CFG_IRQ_EN_BIT 1
`define CFG_NAND_TEST_BIT 2
`define INTRUSION_BIT 6
`define STAT_ROUND_BIT 0
`define STAT_FANS_BIT 1
`define STAT_PIN_BIT 2

// Reset values
`define CONFIG_RESET 8'h00
`define FAN_EN_RESET 8'hff

// Timing: ms figures in microseconds, clock in kHz
`define CLK_KHZ 125000
`define SHORT_CONV_US 11380
`define LONG_CONV_US 34130
`define SHORT_CONV_COUNT 18
`define LONG_CONV_COUNT 2
`define PULSES_PER_REV 2
`define ADDR_SAMPLE_CYCLES 16

`endif

//--- fan_tach_counter.v
`timescale 1ns/1ps
`include "monitor_pin_consts.vh"

module fan_tach_counter #(
	parameter COUNT_W = 16
)(
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Control
	input wire start,
	input wire tachIn,
	input wire [COUNT_W-1:0] limit,
	// Result
	output reg done,
	output reg [COUNT_W-1:0] count
);

	reg tachPrev_q;
	reg [1:0] edges_q;
	reg busy_q;
	reg [COUNT_W-1:0] cnt_q;

	// Duration follows fan speed, not a fixed window
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			tachPrev_q <= 1'b1;
			edges_q <= 2'h0;
			busy_q <= 1'b0;
			cnt_q <= {COUNT_W{1'b0}};
			done <= 1'b0;
			count <= {COUNT_W{1'b0}};
		end
		else
		begin
			tachPrev_q <= tachIn;
			done <= 1'b0;
			if (start)
			begin
				busy_q <= 1'b1;
				edges_q <= 2'h0;
				cnt_q <= {COUNT_W{1'b0}};
			end
			else if (busy_q)
			begin
				// Count one revolution: first edge opens, two more pulses close
				// Runs from start so a stopped fan still reaches the limit
				if ((edges_q == 2'h0) && !tachPrev_q && tachIn)
					cnt_q <= {COUNT_W{1'b0}};
				else
					cnt_q <= cnt_q + {{(COUNT_W-1){1'b0}}, 1'b1};
				if (!tachPrev_q && tachIn)
					edges_q <= edges_q + 2'h1;
				if ((edges_q == `PULSES_PER_REV) && !tachPrev_q && tachIn)
				begin
					busy_q <= 1'b0;
					done <= 1'b1;
					count <= cnt_q;
				end
				else if (cnt_q == limit)
				begin
					// Stalled fan gives full-scale count
					busy_q <= 1'b0;
					done <= 1'b1;
					count <= {COUNT_W{1'b1}};
				end
			end
		end
	end

endmodule

//--- monitor_pin_control.v
`timescale 1ns/1ps
`include "monitor_pin_consts.vh"

module monitor_pin_control #(
	parameter COUNT_W = 16,
	parameter SHORT_CYCLES = (`SHORT_CONV_US * (`CLK_KHZ / 1000)),
	parameter LONG_CYCLES = (`LONG_CONV_US * (`CLK_KHZ / 1000)),
	parameter [COUNT_W-1:0] FAN_LIMIT = 16'hffff
)(
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [3:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdata,
	// Address select / test out pin
	input wire addrSelHighIn,
	input wire addrSelLowIn,
	input wire nandTreeIn,
	output reg addrSelOut,
	output reg addrSelOe_n,
	// Tach or general pins
	input wire [7:0] tachPinIn,
	output reg [7:0] tachPinOut,
	output reg [7:0] tachPinOe_n,
	// Dedicated general pins
	input wire [1:0] generalPinIn,
	output reg [1:0] generalPinOut,
	output reg [1:0] generalPinOe_n,
	// Intrusion and battery
	input wire intrusionIn,
	input wire batterySense,
	output reg intrusionLatched,
	// Interrupt pin
	output reg irqOut_n,
	output reg irqOe_n,
	// Round progress
	output reg convStrobe
);

	localparam ST_SHORT = 3'b001;
	localparam ST_LONG = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [7:0] config_q;
	reg [2:0] status_q;
	reg [2:0] mask_q;
	reg [7:0] tachMode_q;
	reg [1:0] pinDir_q;
	reg [9:0] pinOut_q;
	reg [7:0] fanEn_q;
	reg [1:0] addrLsb_q;
	reg [3:0] addrCnt_q;
	reg [2:0] state_q;
	reg [31:0] convTimer_q;
	reg [4:0] convIdx_q;
	reg [7:0] roundCnt_q;
	reg [2:0] fanSel_q;
	reg fanStart_q;
	reg fanBusy_q;
	reg [COUNT_W-1:0] fanCount_q;
	reg [9:0] pinPrev_q;
	reg intrusion_q;
	wire fanDone;
	wire [COUNT_W-1:0] fanCount;
	wire [2:0] events;
	wire anyFan;
	wire [9:0] pinInAll;

	function wr_hit;
		input [3:0] addr;
		input [3:0] target;
		input we;
		begin
			wr_hit = we && (addr == target);
		end
	endfunction

	assign anyFan = |(fanEn_q & ~tachMode_q);
	assign pinInAll = {generalPinIn, tachPinIn};

	// ------------------------------------------------
	// Monitoring round
	// ------------------------------------------------
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_q <= ST_SHORT;
			convTimer_q <= 32'h0;
			convIdx_q <= 5'h0;
			roundCnt_q <= 8'h0;
			convStrobe <= 1'b0;
		end
		else
		begin
			convStrobe <= 1'b0;
			convTimer_q <= convTimer_q + 32'h1;
			case (state_q)
			ST_SHORT:
				if (convTimer_q == SHORT_CYCLES - 1)
				begin
					convTimer_q <= 32'h0;
					convStrobe <= 1'b1;
					if (convIdx_q == `SHORT_CONV_COUNT - 1)
					begin
						convIdx_q <= 5'h0;
						state_q <= ST_LONG;
					end
					else
						convIdx_q <= convIdx_q + 5'h1;
				end
			ST_LONG:
				if (convTimer_q == LONG_CYCLES - 1)
				begin
					convTimer_q <= 32'h0;
					convStrobe <= 1'b1;
					if (convIdx_q == `LONG_CONV_COUNT - 1)
					begin
						convIdx_q <= 5'h0;
						state_q <= ST_DONE;
					end
					else
						convIdx_q <= convIdx_q + 5'h1;
				end
			ST_DONE:
			begin
				convTimer_q <= 32'h0;
				roundCnt_q <= roundCnt_q + 8'h1;
				state_q <= ST_SHORT;
			end
			default:
				state_q <= ST_SHORT;
			endcase
		end
	end

	// ------------------------------------------------
	// Fan round
	// ------------------------------------------------
	fan_tach_counter #(
		.COUNT_W(COUNT_W)
	) u_tach (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(fanStart_q),
		.tachIn(tachPinIn[fanSel_q]),
		.limit(FAN_LIMIT),
		.done(fanDone),
		.count(fanCount)
	);

	// Only enabled tach-mode fans are visited, so round length varies
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			fanSel_q <= 3'h0;
			fanStart_q <= 1'b0;
			fanBusy_q <= 1'b0;
			fanCount_q <= {COUNT_W{1'b0}};
		end
		else
		begin
			fanStart_q <= 1'b0;
			if (!fanBusy_q)
			begin
				if (fanEn_q[fanSel_q] && !tachMode_q[fanSel_q])
				begin
					fanStart_q <= 1'b1;
					fanBusy_q <= 1'b1;
				end
				else
					fanSel_q <= fanSel_q + 3'h1;
			end
			else if (fanDone)
			begin
				fanBusy_q <= 1'b0;
				fanCount_q <= fanCount;
				fanSel_q <= fanSel_q + 3'h1;
			end
		end
	end

	// ------------------------------------------------
	// Events and registers
	// ------------------------------------------------
	assign events[`STAT_ROUND_BIT] = (state_q == ST_DONE);
	assign events[`STAT_FANS_BIT] = anyFan && &fanSel_q && (fanBusy_q ? fanDone : !fanEn_q[7] | tachMode_q[7]);
	assign events[`STAT_PIN_BIT] = |(pinInAll & ~pinPrev_q);

	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			config_q <= `CONFIG_RESET;
			status_q <= 3'h0;
			mask_q <= 3'h0;
			tachMode_q <= 8'h00;
			pinDir_q <= 2'h0;
			pinOut_q <= 10'h3ff;
			fanEn_q <= `FAN_EN_RESET;
			pinPrev_q <= 10'h3ff;
		end
		else
		begin
			pinPrev_q <= pinInAll;
			if (wr_hit(regAddr, `REG_CONFIG, regWr))
				config_q <= regWdata;
			if (wr_hit(regAddr, `REG_MASK, regWr))
				mask_q <= regWdata[2:0];
			if (wr_hit(regAddr, `REG_TACH_MODE, regWr))
				tachMode_q <= regWdata;
			if (wr_hit(regAddr, `REG_PIN_DIR, regWr))
				pinDir_q <= regWdata[1:0];
			if (wr_hit(regAddr, `REG_PIN_OUT, regWr))
				pinOut_q[7:0] <= regWdata;
			if (wr_hit(regAddr, `REG_PIN_DIR, regWr))
				pinOut_q[9:8] <= regWdata[5:4];
			if (wr_hit(regAddr, `REG_FAN_EN, regWr))
				fanEn_q <= regWdata;
			// Set wins over write-one-to-clear
			if (wr_hit(regAddr, `REG_STATUS, regWr))
				status_q <= (status_q & ~regWdata[2:0]) | events;
			else
				status_q <= status_q | events;
		end
	end

	// Intrusion latch lives on battery: kept through core reset
	always @(posedge core_clk)
	begin
		if (!batterySense)
			intrusion_q <= 1'b0;
		else if (intrusionIn)
			intrusion_q <= 1'b1;
		else if (rstn && wr_hit(regAddr, `REG_INTRUSION, regWr) && regWdata[`INTRUSION_BIT])
			intrusion_q <= 1'b0;
	end

	// ------------------------------------------------
	// Address select sampling
	// ------------------------------------------------
	// Floating seen as neither high nor low on the last sample of the window
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			addrCnt_q <= 4'h0;
			addrLsb_q <= 2'h1;
		end
		else if (addrCnt_q != `ADDR_SAMPLE_CYCLES - 1)
		begin
			addrCnt_q <= addrCnt_q + 4'h1;
			if (addrSelHighIn)
				addrLsb_q <= 2'h2;
			else if (addrSelLowIn)
				addrLsb_q <= 2'h0;
			else
				addrLsb_q <= 2'h1;
		end
	end

	// ------------------------------------------------
	// Pins and read data
	// ------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : tachPins
			always @(posedge core_clk)
			begin
				if (!rstn)
				begin
					tachPinOut[g] <= 1'b0;
					tachPinOe_n[g] <= 1'b1;
				end
				else
				begin
					tachPinOut[g] <= 1'b0;
					tachPinOe_n[g] <= !(tachMode_q[g] && !pinOut_q[g]);
				end
			end
		end
		for (g = 0; g < 2; g = g + 1)
		begin : genPins
			always @(posedge core_clk)
			begin
				if (!rstn)
				begin
					generalPinOut[g] <= 1'b0;
					generalPinOe_n[g] <= 1'b1;
				end
				else
				begin
					generalPinOut[g] <= pinOut_q[8+g];
					generalPinOe_n[g] <= !pinDir_q[g];
				end
			end
		end
	endgenerate

	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			addrSelOut <= 1'b0;
			addrSelOe_n <= 1'b1;
			irqOut_n <= 1'b1;
			irqOe_n <= 1'b1;
			intrusionLatched <= 1'b0;
			regRdata <= 8'h00;
		end
		else
		begin
			addrSelOut <= nandTreeIn;
			addrSelOe_n <= !config_q[`CFG_NAND_TEST_BIT];
			irqOut_n <= 1'b0;
			// Driven low only when enabled and pending, else released
			irqOe_n <= !(config_q[`CFG_IRQ_EN_BIT] && |(status_q & mask_q));
			intrusionLatched <= intrusion_q;
			regRdata <= 8'h00;
			if (regRd)
			begin
				case (regAddr)
				`REG_CONFIG: regRdata <= config_q;
				`REG_STATUS: regRdata <= {5'h0, status_q};
				`REG_MASK: regRdata <= {5'h0, mask_q};
				`REG_TACH_MODE: regRdata <= tachMode_q;
				`REG_PIN_DIR: regRdata <= {2'h0, pinOut_q[9:8], 2'h0, pinDir_q};
				`REG_PIN_OUT: regRdata <= pinOut_q[7:0];
				`REG_PIN_IN: regRdata <= tachPinIn;
				`REG_FAN_EN: regRdata <= fanEn_q;
				`REG_ADDR_LSB: regRdata <= {generalPinIn, 4'h0, addrLsb_q};
				`REG_ROUND: regRdata <= roundCnt_q;
				`REG_FAN_SEL: regRdata <= {5'h0, fanSel_q};
				`REG_FAN_COUNT: regRdata <= fanCount_q[COUNT_W-1:COUNT_W-8];
				`REG_INTRUSION: regRdata <= {1'b0, intrusion_q, 6'h0};
				default: regRdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

//--- monitor_pin_asserts.sv
`timescale 1ns/1ps
// ----------------
// Port checks
// ----------------
module monitor_pin_asserts #(
	parameter SHORT_CYCLES = 20,
	parameter LONG_CYCLES = 50
)(
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [3:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWr,
	input wire regRd,
	input wire [7:0] regRdata,
	// Pins
	input wire nandTreeIn,
	input wire addrSelOut,
	input wire addrSelOe_n,
	input wire [7:0] tachPinOe_n,
	input wire [1:0] generalPinOe_n,
	input wire intrusionIn,
	input wire batterySense,
	input wire intrusionLatched,
	input wire irqOut_n,
	input wire irqOe_n,
	input wire convStrobe
);
	reg irqEn_q;
	reg [15:0] gap_q;
	wire clr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	assign clr = regWr && regAddr == 4'hc && regWdata[6];
	always @(posedge core_clk)
	begin
		if (!rstn)
			irqEn_q <= 1'b0;
		else if (regWr && regAddr == 4'h0)
			irqEn_q <= regWdata[1];
	end
	// Saturates so a stalled round still trips the upper bound
	always @(posedge core_clk)
	begin
		if (!rstn || convStrobe)
			gap_q <= 16'h0000;
		else if (gap_q != 16'hffff)
			gap_q <= gap_q + 16'h0001;
	end
	a_irq_needs_enable: assert property (!irqEn_q && !$past(irqEn_q) |-> irqOe_n)
		else $error("irq driven while disabled");
	a_irq_pin_low: assert property ($past(rstn) |-> !irqOut_n)
		else $error("irq level wrong");
	a_reset_release: assert property ($rose(rstn) |-> irqOe_n && addrSelOe_n && &tachPinOe_n && &generalPinOe_n)
		else $error("pin driven after reset");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data without read");
	a_nand_follow: assert property (!addrSelOe_n |-> addrSelOut == $past(nandTreeIn))
		else $error("test result not presented");
	a_intr_capture: assert property (intrusionIn && batterySense |-> ##[1:3] intrusionLatched)
		else $error("intrusion not latched");
	a_intr_hold: assert property (intrusionLatched && batterySense && $past(batterySense) && !clr && !$past(clr) |=> intrusionLatched)
		else $error("intrusion lost");
	a_strobe_early: assert property (convStrobe |-> gap_q >= SHORT_CYCLES - 1)
		else $error("conversion too short");
	a_strobe_late: assert property (gap_q <= LONG_CYCLES + 2)
		else $error("conversion too long");
endmodule

//--- fan_tach_model.sv
`timescale 1ns/1ps
// ----------------
// Board fans
// ----------------
module fan_tach_model #(
	parameter HALF = 130
)(
	input wire core_clk,
	output reg [7:0] tach
);
	reg [15:0] cnt_q;
	// One speed for all, so any fan gives the same count
	initial
	begin
		tach = 8'h00;
		cnt_q = 16'h0000;
	end
	always @(posedge core_clk)
	begin
		cnt_q <= (cnt_q == HALF - 1) ? 16'h0000 : cnt_q + 16'h0001;
		if (cnt_q == HALF - 1)
			tach <= ~tach;
	end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
// ----------------
// Bench
// ----------------
module testbench;
	reg core_clk, rstn, regWr, regRd, addrSelHighIn, addrSelLowIn, nandTreeIn, intrusionIn, batterySense;
	reg [3:0] regAddr;
	reg [7:0] regWdata, got;
	reg [1:0] generalPinIn;
	wire [7:0] regRdata, tachPinOut, tachPinOe_n, fanLine, tachPinIn;
	wire [1:0] generalPinOut, generalPinOe_n;
	wire addrSelOut, addrSelOe_n, intrusionLatched, irqOut_n, irqOe_n, convStrobe;
	integer errors, num_checks, k;
	integer cyc = 0;
	// Pull-up: a pin is low only where something drives it
	assign tachPinIn = fanLine & (tachPinOe_n | tachPinOut);
	fan_tach_model fans (.core_clk(core_clk), .tach(fanLine));
	monitor_pin_control #(.SHORT_CYCLES(20), .LONG_CYCLES(50)) uut (
		.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .addrSelHighIn(addrSelHighIn), .addrSelLowIn(addrSelLowIn), .nandTreeIn(nandTreeIn),
		.addrSelOut(addrSelOut), .addrSelOe_n(addrSelOe_n), .tachPinIn(tachPinIn), .tachPinOut(tachPinOut),
		.tachPinOe_n(tachPinOe_n), .generalPinIn(generalPinIn), .generalPinOut(generalPinOut),
		.generalPinOe_n(generalPinOe_n), .intrusionIn(intrusionIn), .batterySense(batterySense),
		.intrusionLatched(intrusionLatched), .irqOut_n(irqOut_n), .irqOe_n(irqOe_n), .convStrobe(convStrobe)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task chk(input string n, input [7:0] e, input [7:0] s);
	begin
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			errors = errors + 1;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	end
	endtask
	task waitc(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	task wr(input [3:0] a, input [7:0] d);
	begin
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	end
	endtask
	task rdRaw(input [3:0] a);
	begin
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 got = regRdata;
	end
	endtask
	task rd(input [3:0] a, input [7:0] m, input [7:0] e);
	begin
		rdRaw(a);
		chk("rdata", e, got & m);
	end
	endtask
	task report_and_stop;
	begin
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// Fan rounds are slow; ceiling leaves room for six
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 40000)
		begin
			errors = errors + 1;
			report_and_stop;
		end
	end
	initial
	begin
		errors = 0;
		num_checks = 0;
		{rstn, regWr, regRd, addrSelLowIn, nandTreeIn, intrusionIn} = 6'h00;
		{addrSelHighIn, batterySense} = 2'b10;
		regAddr = 4'h0;
		regWdata = 8'h00;
		generalPinIn = 2'b00;
		waitc(6);
		rstn <= 1'b1;
		batterySense <= 1'b1;
		waitc(20);
		addrSelHighIn <= 1'b0;
		rd(4'h0, 8'hff, 8'h00);
		rd(4'h7, 8'hff, 8'hff);
		rd(4'h8, 8'h03, 8'h02);
		rd(4'hd, 8'hff, 8'h00);
		waitc(1);
		intrusionIn <= 1'b1;
		waitc(1);
		intrusionIn <= 1'b0;
		rd(4'hc, 8'h40, 8'h40);
		// Main power drop: latch must ride through on battery
		waitc(1);
		rstn <= 1'b0;
		waitc(3);
		rstn <= 1'b1;
		rd(4'hc, 8'h40, 8'h40);
		wr(4'hc, 8'h40);
		rd(4'hc, 8'h40, 8'h00);
		wr(4'h2, 8'h01);
		wr(4'h1, 8'hff);
		waitc(470);
		rd(4'h1, 8'h01, 8'h01);
		#1 chk("irqOe", 8'h01, {7'h00, irqOe_n});
		wr(4'h0, 8'h02);
		waitc(2);
		#1 chk("irqOe", 8'h00, {7'h00, irqOe_n});
		wr(4'h1, 8'h01);
		waitc(2);
		#1 chk("irqOe", 8'h01, {7'h00, irqOe_n});
		wr(4'h0, 8'h06);
		nandTreeIn <= 1'b1;
		waitc(2);
		#1 chk("addrSel", 8'h01, {6'h00, addrSelOe_n, addrSelOut});
		wr(4'h3, 8'h01);
		wr(4'h5, 8'h00);
		waitc(2);
		#1 chk("tachOe", 8'hfe, tachPinOe_n);
		chk("tachOut", 8'h00, tachPinOut);
		rd(4'h6, 8'h01, 8'h00);
		wr(4'h5, 8'h01);
		waitc(2);
		#1 chk("tachOe", 8'hff, tachPinOe_n);
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h11);
		generalPinIn <= 2'b10;
		waitc(2);
		#1 chk("genPin", 8'h09, {4'h0, generalPinOe_n, generalPinOut});
		rd(4'h8, 8'hc0, 8'h80);
		wr(4'h1, 8'h02);
		got = 8'h00;
		for (k = 0; k < 200 && got[1] !== 1'b1; k = k + 1)
		begin
			waitc(50);
			rdRaw(4'h1);
		end
		chk("fanDone", 8'h02, got & 8'h02);
		rd(4'hb, 8'hff, 8'h02);
		report_and_stop;
	end
endmodule
bind monitor_pin_control monitor_pin_asserts #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chkr (
	.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .nandTreeIn(nandTreeIn), .addrSelOut(addrSelOut), .addrSelOe_n(addrSelOe_n),
	.tachPinOe_n(tachPinOe_n), .generalPinOe_n(generalPinOe_n), .intrusionIn(intrusionIn),
	.batterySense(batterySense), .intrusionLatched(intrusionLatched), .irqOut_n(irqOut_n), .irqOe_n(irqOe_n),
	.convStrobe(convStrobe)
);
